/* logic/vic_top.v */
// Vectored interrupt controller: enable registers, priority, vector fetch.
// Assumes flags are held in the peripherals and all inputs except arst_n are synchronous.
//
// Notes on behaviour
// (RULE_01) Vectors live in the top 32 ROM bytes, one 16-bit word each.
// (RULE_02) Power-up, reset pin or watchdog expiry select reset vector (15).
// (RULE_03) Nonmaskable pin and oscillator fault share priority 14.
// (RULE_04) Port 0 pin 0 priority 13; port 0 pin 1 priority 12.
// (RULE_05) Watchdog 10, capture 9, overflow 8, rx 7, tx 6, tp 4, basic 1.
// (RULE_06) Any port 2 pin flag requests the shared priority 3 vector.
// (RULE_07) Any port 1 pin flag requests the shared priority 2 vector.
// (RULE_08) Any port 0 pin 2..7 flag requests the priority 0 vector.
// (RULE_09) Timer and timer/port flags stay in their own modules.
// (RULE_10) Nonmaskable pin request ignores individual and global enables.
// (RULE_11) Oscillator fault needs its own enable but ignores global enable.
// (RULE_12) Unassigned enable bits hold no storage and read zero.
// (RULE_13) Address 0: watchdog, osc fault, port0 pin0, pin1 enables.
// (RULE_14) Address 1: rx bit 0, tx bit 1, timer/port bit 3, basic bit 7.
// (RULE_15) Highest pending enabled priority wins; maskable needs both enables.
// (RULE_16) An accepted interrupt wakes from low power; return restores mode.
`timescale 1ns/1ns
`include "vic_defines.vh"

module vic_top (
  // Clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // Byte register port
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // Reset causes
  input  wire        reset_cause,
  input  wire        watchdog_flag,
  // Peripheral flags
  input  wire        ext_nonmaskable_flag,
  input  wire        osc_fault_flag,
  input  wire [7:0]  port0_pin_flags,
  input  wire [7:0]  port1_pin_flags,
  input  wire [7:0]  port2_pin_flags,
  input  wire        watchdog_interval_flag,
  input  wire        capture_compare0_flag,
  input  wire        timer_overflow_flag,
  input  wire        serial_rx_flag,
  input  wire        serial_tx_flag,
  input  wire        tp_counter1_flag,
  input  wire        tp_counter2_flag,
  input  wire        tp_gate_flag,
  input  wire        basic_timer_flag,
  // CPU side
  input  wire        global_irq_en,
  input  wire        irq_ack,
  input  wire        return_from_interrupt,
  input  wire        low_power_req,
  output wire        irq_req,
  output reg  [3:0]  irq_level,
  output reg  [15:0] vector_addr,
  output reg         vector_fetch,
  output reg         cpu_awake,
  // ROM read port for vector words
  output reg  [15:0] rom_addr,
  output reg         rom_rd,
  input  wire [15:0] rom_rdata,
  output reg  [15:0] handler_addr,
  output reg         handler_valid
);

  // Stored enable bits; unassigned positions have no storage.
  reg  [3:0]  ie1_r;
  reg  [3:0]  ie2_r;
  // Fetch sequencing and sleep bookkeeping.
  reg         fetch_r;
  reg         saved_sleep_r;
  reg         saved_sleep_nxt;
  reg         cpu_awake_nxt;
  // Decoded write strobes.
  wire        wr_ie1;
  wire        wr_ie2;
  // Per-source requests after gating.
  wire        maskable_ok;
  wire        rq_reset;
  wire        rq_nmi;
  wire        rq_osc;
  wire        rq_p00;
  wire        rq_p01;
  wire        rq_wdt;
  wire        rq_cc0;
  wire        rq_tov;
  wire        rq_rx;
  wire        rq_tx;
  wire        rq_tp;
  wire        rq_p2;
  wire        rq_p1;
  wire        rq_bt;
  wire        rq_p0hi;
  // Priority resolution.
  reg  [15:0] req;
  reg  [3:0]  best;
  reg         any;
  wire        take;
  wire [15:0] next_vec;
  integer     i;

  // Word address of the vector for a priority level.
  function [15:0] vec_of;
    input [3:0] lvl;
    begin
      vec_of = `VIC_VEC_BASE + {11'h000, lvl, 1'b0}; // [RULE_01]
    end
  endfunction

  // Address match for one enable register.
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // Packs the assigned bits of the second register into storage.
  function [3:0] pack_ie2;
    input [7:0] d;
    begin
      pack_ie2 = {d[`VIC_IE2_BT_BIT], d[`VIC_IE2_TP_BIT],
                  d[`VIC_IE2_TX_BIT], d[`VIC_IE2_RX_BIT]};
    end
  endfunction

  // Spreads the stored bits back to their byte positions.
  function [7:0] unpack_ie2;
    input [3:0] s;
    begin
      unpack_ie2 = 8'h00;
      unpack_ie2[`VIC_IE2_RX_BIT] = s[0];
      unpack_ie2[`VIC_IE2_TX_BIT] = s[1];
      unpack_ie2[`VIC_IE2_TP_BIT] = s[2];
      unpack_ie2[`VIC_IE2_BT_BIT] = s[3];
    end
  endfunction

  // Write strobes of the two enable registers.
  assign wr_ie1 = reg_wr & hit(reg_addr, `VIC_IE1_ADDR);
  assign wr_ie2 = reg_wr & hit(reg_addr, `VIC_IE2_ADDR);

  // First enable register.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ie1_r <= `VIC_IE_BITS_RESET; // [RULE_13]
    end else if (wr_ie1) begin
      ie1_r <= reg_wdata[3:0]; // [RULE_13]
    end
  end

  // Second enable register.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ie2_r <= `VIC_IE_BITS_RESET; // [RULE_14]
    end else if (wr_ie2) begin
      ie2_r <= pack_ie2(reg_wdata); // [RULE_14]
    end
  end

  // Read mux; absent bits and unmapped addresses read zero.
  always @* begin
    reg_rdata = 8'h00; // [RULE_12]
    if (hit(reg_addr, `VIC_IE1_ADDR)) begin
      reg_rdata = {4'h0, ie1_r}; // [RULE_13]
    end else if (hit(reg_addr, `VIC_IE2_ADDR)) begin
      reg_rdata = unpack_ie2(ie2_r); // [RULE_14]
    end
  end

  // Source gating by individual and global enables.
  assign maskable_ok = global_irq_en; // [RULE_15]
  assign rq_reset = reset_cause | watchdog_flag; // [RULE_02]
  assign rq_nmi   = ext_nonmaskable_flag; // [RULE_10]
  assign rq_osc   = osc_fault_flag & ie1_r[`VIC_IE1_OSC_BIT]; // [RULE_11]
  assign rq_p00   = maskable_ok & port0_pin_flags[0]
                    & ie1_r[`VIC_IE1_P00_BIT]; // [RULE_04]
  assign rq_p01   = maskable_ok & port0_pin_flags[1]
                    & ie1_r[`VIC_IE1_P01_BIT]; // [RULE_04]
  assign rq_wdt   = maskable_ok & watchdog_interval_flag
                    & ie1_r[`VIC_IE1_WDT_BIT]; // [RULE_05]
  assign rq_cc0   = maskable_ok & capture_compare0_flag; // [RULE_09]
  assign rq_tov   = maskable_ok & timer_overflow_flag; // [RULE_09]
  assign rq_rx    = maskable_ok & serial_rx_flag & ie2_r[0]; // [RULE_05]
  assign rq_tx    = maskable_ok & serial_tx_flag & ie2_r[1]; // [RULE_05]
  assign rq_tp    = maskable_ok & ie2_r[2]
                    & (tp_counter1_flag | tp_counter2_flag
                       | tp_gate_flag); // [RULE_09]
  assign rq_p2    = maskable_ok & (|port2_pin_flags); // [RULE_06]
  assign rq_p1    = maskable_ok & (|port1_pin_flags); // [RULE_07]
  assign rq_bt    = maskable_ok & basic_timer_flag & ie2_r[3]; // [RULE_05]
  assign rq_p0hi  = maskable_ok & (|port0_pin_flags[7:2]); // [RULE_08]

  // Request vector indexed by priority level.
  always @* begin
    req = 16'h0000;
    req[`VIC_PRI_RESET] = rq_reset; // [RULE_02]
    req[`VIC_PRI_NMI]   = rq_nmi | rq_osc; // [RULE_03]
    req[`VIC_PRI_P00]   = rq_p00; // [RULE_04]
    req[`VIC_PRI_P01]   = rq_p01;
    req[`VIC_PRI_WDT]   = rq_wdt; // [RULE_05]
    req[`VIC_PRI_CC0]   = rq_cc0;
    req[`VIC_PRI_TOV]   = rq_tov;
    req[`VIC_PRI_RX]    = rq_rx;
    req[`VIC_PRI_TX]    = rq_tx;
    req[`VIC_PRI_TP]    = rq_tp;
    req[`VIC_PRI_P2]    = rq_p2; // [RULE_06]
    req[`VIC_PRI_P1]    = rq_p1; // [RULE_07]
    req[`VIC_PRI_BT]    = rq_bt;
    req[`VIC_PRI_P0HI]  = rq_p0hi; // [RULE_08]
  end

  // Highest set level wins.
  always @* begin
    best = 4'h0;
    any  = 1'b0;
    for (i = 0; i < 16; i = i + 1) begin
      if (req[i]) begin
        best = i[3:0]; // [RULE_15]
        any  = 1'b1;
      end
    end
  end

  // Acknowledge is taken only while no fetch is in flight.
  assign take     = irq_ack & any & ~fetch_r;
  assign irq_req  = any & ~fetch_r;
  assign next_vec = vec_of(best); // [RULE_01]

  // Fetch phase marker, one cycle after an accepted acknowledge.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_r <= 1'b0;
    end else begin
      fetch_r <= take;
    end
  end

  // Granted level and vector word address.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_level   <= `VIC_LEVEL_RESET;
      vector_addr <= `VIC_VEC_TOP;
      rom_addr    <= `VIC_VEC_TOP;
    end else if (take) begin
      irq_level   <= best;
      vector_addr <= next_vec; // [RULE_01]
      rom_addr    <= next_vec;
    end
  end

  // One-cycle fetch pulses.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vector_fetch <= 1'b0;
      rom_rd       <= 1'b0;
    end else begin
      vector_fetch <= take;
      rom_rd       <= take;
    end
  end

  // Handler address taken from the vector word.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      handler_addr  <= `VIC_HANDLER_RESET;
      handler_valid <= 1'b0;
    end else begin
      handler_valid <= fetch_r;
      if (fetch_r) begin
        handler_addr <= rom_rdata; // [RULE_01]
      end
    end
  end

  // Sleep state: remembers whether a request woke a sleeping core.
  always @* begin
    cpu_awake_nxt   = cpu_awake;
    saved_sleep_nxt = saved_sleep_r;
    if (take) begin
      cpu_awake_nxt   = 1'b1; // [RULE_16]
      saved_sleep_nxt = saved_sleep_r | ~cpu_awake;
    end else if (fetch_r) begin
      cpu_awake_nxt   = 1'b1;
    end else if (return_from_interrupt) begin
      cpu_awake_nxt   = ~saved_sleep_r; // [RULE_16]
      saved_sleep_nxt = 1'b0;
    end else if (low_power_req && !any) begin
      cpu_awake_nxt   = 1'b0;
    end else if (any) begin
      cpu_awake_nxt   = 1'b1; // [RULE_16]
      saved_sleep_nxt = saved_sleep_r | ~cpu_awake;
    end
  end

  // Sleep state registers.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_awake     <= 1'b1;
      saved_sleep_r <= 1'b0;
    end else begin
      cpu_awake     <= cpu_awake_nxt;
      saved_sleep_r <= saved_sleep_nxt;
    end
  end

endmodule // vic_top

/* pkg/vic_defines.vh */
// Constants of the vectored interrupt controller: enable register map,
// vector word addresses and priority levels.
// Assumes byte-wide register access at the bottom of the address space.
`ifndef VIC_DEFINES_VH
`define VIC_DEFINES_VH

// Enable register addresses.
`define VIC_IE1_ADDR        8'h00
`define VIC_IE2_ADDR        8'h01
`define VIC_IE_RESET        8'h00
`define VIC_IE_BITS_RESET   4'h0
`define VIC_LEVEL_RESET     4'h0
`define VIC_HANDLER_RESET   16'h0000

// Bit positions of the first enable register.
`define VIC_IE1_WDT_BIT     0
`define VIC_IE1_OSC_BIT     1
`define VIC_IE1_P00_BIT     2
`define VIC_IE1_P01_BIT     3

// Bit positions of the second enable register.
`define VIC_IE2_RX_BIT      0
`define VIC_IE2_TX_BIT      1
`define VIC_IE2_TP_BIT      3
`define VIC_IE2_BT_BIT      7

// Vector table, top 32 bytes of ROM.
`define VIC_VEC_TOP         16'hFFFE
`define VIC_VEC_BASE        16'hFFE0

// Priority levels.
`define VIC_PRI_RESET       4'hF
`define VIC_PRI_NMI         4'hE
`define VIC_PRI_P00         4'hD
`define VIC_PRI_P01         4'hC
`define VIC_PRI_WDT         4'hA
`define VIC_PRI_CC0         4'h9
`define VIC_PRI_TOV         4'h8
`define VIC_PRI_RX          4'h7
`define VIC_PRI_TX          4'h6
`define VIC_PRI_TP          4'h4
`define VIC_PRI_P2          4'h3
`define VIC_PRI_P1          4'h2
`define VIC_PRI_BT          4'h1
`define VIC_PRI_P0HI        4'h0

`endif

/* tb/tb.sv */
// Testbench of the interrupt controller: one-hot and random flags.
// Assumes vic_top, vic_props and vic_rom_model are compiled first.
`timescale 1ns/1ns
module tb;
  logic        clk = 0, arst_n = 0, reg_wr = 0, global_irq_en = 0;
  logic        irq_ack = 0, low_power_req = 0, irq_req, vector_fetch;
  logic        cpu_awake, rom_rd, handler_valid;
  logic        return_from_interrupt = 0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0]  irq_level;
  logic [15:0] s = 16'h0000, vector_addr, rom_addr, rom_rdata, handler_addr;
  logic [31:0] seed = 32'd97;
  int          fails = 0, cmp_count = 0;
  logic [3:0]  lv [16] = '{4'hF, 4'hF, 4'hE, 4'hE, 4'hD, 4'hC, 4'hA, 4'h9,
                           4'h8, 4'h7, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  always #50 clk = ~clk;
  vic_top DUT (.*, .reset_cause(s[0]), .watchdog_flag(s[1]),
    .ext_nonmaskable_flag(s[2]), .osc_fault_flag(s[3]),
    .port0_pin_flags({s[15], 5'h00, s[5], s[4]}),
    .port1_pin_flags({s[13], 7'h00}), .port2_pin_flags({3'h0, s[12], 4'h0}),
    .watchdog_interval_flag(s[6]), .capture_compare0_flag(s[7]),
    .timer_overflow_flag(s[8]), .serial_rx_flag(s[9]),
    .serial_tx_flag(s[10]), .tp_counter1_flag(s[11]),
    .tp_counter2_flag(1'b0), .tp_gate_flag(1'b0),
    .basic_timer_flag(s[14]));
  vic_rom_model u_rom (.*);
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [4:0] pick(logic [15:0] v, logic [7:0] a, b,
                                      logic g);
    logic [15:0] m;
    pick = 5'h00;
    m = {g, g & b[7], g, g, g & b[3], g & b[1], g & b[0], g, g,
         g & a[0], g & a[3], g & a[2], a[1], 3'b111};
    for (int i = 15; i >= 0; i--) if (v[i] & m[i]) pick = {1'b1, lv[i]};
  endfunction
  task automatic ck(string n, logic [15:0] v, e);
    cmp_count++;
    if (v !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic wr(logic [7:0] a, d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, e);
    @(posedge clk);
    reg_addr <= a;
    #1 ck("reg_rdata", 16'(reg_rdata), 16'(e));
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #1000000 fails++;
    test_done();
  end
  initial begin
    logic [7:0] a, b, u;
    logic [4:0] x;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    low_power_req <= 1'b1;
    for (int k = 0; k < 48; k++) begin
      a = k < 16 ? 8'hFF : xs();
      b = k < 16 ? 8'hFF : xs();
      u = xs() | 8'h02;
      wr(8'h00, a);
      wr(8'h01, b);
      wr(u, 8'hFF);
      rd(8'h00, a & 8'h0F);
      rd(8'h01, b & 8'h8B);
      rd(u, 8'h00);
      @(posedge clk);
      s <= k < 16 ? 16'h0001 << k : {xs(), xs()} & {xs(), xs()};
      global_irq_en <= (k < 16) || (xs() > 8'h50);
      @(posedge clk);
      #1 x = pick(s, a, b, global_irq_en);
      ck("irq_req", 16'(irq_req), 16'(x[4]));
      @(posedge clk);
      if (x[4]) begin
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
        @(posedge clk);
        #1 ck("irq_level", 16'(irq_level), 16'(x[3:0]));
        ck("handler", handler_addr, ~{11'h7FF, x[3:0], 1'b0});
        ck("awake", 16'(cpu_awake), 16'h0001);
        @(posedge clk);
        s <= 16'h0000;
        return_from_interrupt <= 1'b1;
        low_power_req <= 1'b0;
        @(posedge clk);
        return_from_interrupt <= 1'b0;
        low_power_req <= 1'b1;
        #1 ck("awake_return_from_interrupt", 16'(cpu_awake), 16'h0000);
      end
      s <= 16'h0000;
      repeat (2) @(posedge clk);
      $display("test %0d done", k);
    end
    test_done();
  end
endmodule // tb
bind vic_top vic_props u_props (.*);

/* tb/vic_props.sv */
// Checker of the interrupt controller ports.
// Assumes it is bound into vic_top.
`timescale 1ns/1ns
module vic_props (
  // Watched ports
  input logic        clk, arst_n, irq_ack, irq_req, vector_fetch,
  input logic        rom_rd, handler_valid, ext_nonmaskable_flag,
  input logic [3:0]  irq_level,
  input logic [7:0]  reg_addr, reg_rdata,
  input logic [15:0] vector_addr, rom_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_ACK: assert property (irq_ack && irq_req |=> vector_fetch && rom_rd)
    else $error("no fetch after ack");
  AST_HV: assert property (vector_fetch |=> handler_valid)
    else $error("no handler after fetch");
  AST_VA: assert property (vector_fetch |-> vector_addr == {11'h7FF, irq_level, 1'b0})
    else $error("bad vector address");
  AST_RA: assert property (rom_rd |-> rom_addr == vector_addr)
    else $error("bad rom address");
  AST_NMI: assert property (ext_nonmaskable_flag && !vector_fetch && !handler_valid |-> irq_req)
    else $error("nonmaskable not requested");
  AST_E1: assert property (reg_addr == 8'h00 |-> reg_rdata[7:4] == 4'h0)
    else $error("absent bits read one");
  AST_E2: assert property (reg_addr == 8'h01 |-> (reg_rdata & 8'h74) == 8'h00)
    else $error("absent bits read one");
  AST_UN: assert property (reg_addr > 8'h01 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // vic_props

/* tb/vic_rom_model.sv */
// Vector ROM model: word valid while the read strobe stands.
// Assumes the handler address of a vector is its inverted address.
`timescale 1ns/1ns
module vic_rom_model (
  input  logic        clk, rom_rd,
  input  logic [15:0] rom_addr,
  output logic [15:0] rom_rdata
);
  logic [15:0] junk = 16'h0000;
  always @(posedge clk) junk <= junk + 16'h1357;
  assign rom_rdata = rom_rd ? ~rom_addr : junk;
endmodule // vic_rom_model
